// ===== rtl/timer_wrap_access.sv
`timescale 1ns/1ps
// Summary of operation
// R1: low window accesses selected register bits 7:0
// R2: low window read latches counter, mode zero
// R3: mode one: timer low read latches counter
// R4: middle window accesses selected bits 15:8
// R5: middle read with counter selected: latched copy
// R6: high window accesses selected bits 23:16
// R7: high read with counter selected: latched copy
// R8: flag 5 set on wrap match two
// R9: flag 4 set on wrap match one
// R10: flag 3 set on overflow period wrap
// R11: flag 2 set on timer match two
// R12: flag 1 set on timer match one
// R13: flag 0 set on timer period wrap
// R14: extended: flags 7,6 on combined matches
// R15: enable bits 0-2 gate timer flags
// R16: enable bits 3-5 gate overflow flags
// R17: enable bits 7,6 extended; else read zero
// R18: select codes pick counter, capture, period, matches
// R19: flags reset zero, write zero clears, set wins
// R20: interrupt when any enabled flag set
module timer_wrap_access
  import timer_wrap_pkg::*;
#(
  parameter bit EXTENDED = 1'b1,   // Adds the combined-match flags 7:6.
  parameter int WRAP_W   = 24,     // Overflow-side register width.
  parameter int TICK_W   = 16      // Timer register width.
)(
  // Clock and reset.
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst_n,
  // Special-function register bus.
  input  wire logic [7:0]           i_sfr_addr,
  input  wire logic                 i_sfr_wr,
  input  wire logic                 i_sfr_rd,
  input  wire logic [7:0]           i_sfr_wdata,
  output logic      [7:0]           o_sfr_rdata,
  // Fields held by neighbouring registers.
  input  wire logic [2:0]           i_overflow_window_select,
  input  wire logic                 i_latch_mode,
  input  wire logic                 i_timer_low_window_rd,
  // Counting core status and events.
  input  wire logic [WRAP_W-1:0]    i_wrap_counter,
  input  wire logic [WRAP_W-1:0]    i_wrap_capture,
  input  wire core_events_t         i_core_events,
  // Counting core configuration.
  output logic      [WRAP_W-1:0]    o_wrap_period,
  output logic      [WRAP_W-1:0]    o_wrap_match_one,
  output logic      [WRAP_W-1:0]    o_wrap_match_two,
  output counter_write_t            o_counter_write,
  // Interrupt request.
  output logic                      o_timer_irq
);

  // Returns one byte lane of a 24-bit internal register.
  function automatic logic [7:0] lane_of(input logic [23:0] w,
                                         input logic [1:0]  lane);
    logic [7:0] b;
    b = 8'h00;
    if (lane == LANE_LOW)
      b = w[7:0];
    else if (lane == LANE_MID)
      b = w[15:8];
    else if (lane == LANE_HIGH)
      b = w[23:16];
    return b;
  endfunction : lane_of

  // Implemented flag bits depend on the variant.
  localparam logic [7:0] LIVE_BITS = EXTENDED ? FULL_BITS_MASK
                                              : BASE_BITS_MASK;

  // Internal registers and visible state.
  logic [7:0]        flags_q;        // Sticky event flags.
  logic [7:0]        enables_q;      // Interrupt enables.
  logic [WRAP_W-1:0] period_q;       // Overflow period.
  logic [WRAP_W-1:0] match_one_q;    // Overflow compare one.
  logic [WRAP_W-1:0] match_two_q;    // Overflow compare two.
  logic [WRAP_W-1:0] latch_q;        // Frozen copy of the counter.
  logic [7:0]        rdata_q;        // Read data holding register.
  counter_write_t    cwr_q;          // Byte write toward the core.

  // Address decode, one strobe per register address.
  wire hit_flags   = (i_sfr_addr == ADDR_EVENT_FLAGS);
  wire hit_low     = (i_sfr_addr == ADDR_WRAP_LOW);
  wire hit_mid     = (i_sfr_addr == ADDR_WRAP_MID);
  wire hit_high    = (i_sfr_addr == ADDR_WRAP_HIGH);
  wire hit_enables = (i_sfr_addr == ADDR_EVENT_ENABLES);
  wire hit_window  = hit_low | hit_mid | hit_high;

  // Selected byte lane of the window being accessed.
  wire [1:0] lane = hit_mid  ? LANE_MID  :
                    hit_high ? LANE_HIGH : LANE_LOW;

  // Selection decode of the overflow window select field.
  wire sel_cnt = (i_overflow_window_select == SEL_COUNTER);   // [R18]
  wire sel_cap = (i_overflow_window_select == SEL_CAPTURE);   // [R18]
  wire sel_per = (i_overflow_window_select == SEL_PERIOD);    // [R18]
  wire sel_m1  = (i_overflow_window_select == SEL_MATCH_ONE); // [R18]
  wire sel_m2  = (i_overflow_window_select == SEL_MATCH_TWO); // [R18]

  // Which read moments freeze the overflow counter.
  wire latch_by_low   = i_sfr_rd & hit_low & sel_cnt & ~i_latch_mode; // [R2]
  wire latch_by_timer = i_timer_low_window_rd & sel_cnt
                        & i_latch_mode;                             // [R3]
  wire take_latch     = latch_by_low | latch_by_timer;

  // The counter view: the low byte in mode zero is read live, every
  // other byte comes from the copy so the three reads stay coherent.
  wire [23:0] cnt_view = {latch_q[23:8],
                          i_latch_mode ? latch_q[7:0]
                                       : i_wrap_counter[7:0]};  // [R5] [R7]

  // The selected internal register; reserved codes read zero.
  wire [23:0] sel_word = sel_cnt ? cnt_view       :
                         sel_cap ? i_wrap_capture :
                         sel_per ? period_q       :
                         sel_m1  ? match_one_q    :
                         sel_m2  ? match_two_q    : 24'h000000;  // [R18]

  // Byte returned through a window.
  wire [7:0] win_rd = lane_of(sel_word, lane);          // [R1] [R4] [R6]

  // Read mux over all mapped addresses; unmapped reads return zero.
  wire [7:0] rd_mux = hit_flags   ? (flags_q & LIVE_BITS)   :
                      hit_enables ? (enables_q & LIVE_BITS) :
                      hit_window  ? win_rd                  : 8'h00; // [R17]

  // Window write strobes, one per lane, for writable selections.
  wire       win_wr    = i_sfr_wr & hit_window;
  wire [2:0] lane_hot  = {hit_high, hit_mid, hit_low};
  wire [2:0] we_per    = {3{win_wr & sel_per}} & lane_hot;
  wire [2:0] we_m1     = {3{win_wr & sel_m1}}  & lane_hot;
  wire [2:0] we_m2     = {3{win_wr & sel_m2}}  & lane_hot;
  wire [2:0] we_cnt    = {3{win_wr & sel_cnt}} & lane_hot;

  // Combined matches: overflow counter equal and timer compare hit.
  wire comb_one = EXTENDED & i_core_events.tick_match_one
                  & (i_wrap_counter == match_one_q);           // [R14]
  wire comb_two = EXTENDED & i_core_events.tick_match_two
                  & (i_wrap_counter == match_two_q);           // [R14]

  // Hardware set requests, one per flag bit.
  wire [7:0] set_req;
  assign set_req[BIT_TICK_WRAP]      = i_core_events.tick_wrap;      // [R13]
  assign set_req[BIT_TICK_MATCH_ONE] = i_core_events.tick_match_one; // [R12]
  assign set_req[BIT_TICK_MATCH_TWO] = i_core_events.tick_match_two; // [R11]
  assign set_req[BIT_WRAP_PERIOD]    = i_core_events.wrap_period;    // [R10]
  assign set_req[BIT_WRAP_MATCH_ONE] = i_core_events.wrap_match_one; // [R9]
  assign set_req[BIT_WRAP_MATCH_TWO] = i_core_events.wrap_match_two; // [R8]
  assign set_req[BIT_COMB_MATCH_ONE] = comb_one;
  assign set_req[BIT_COMB_MATCH_TWO] = comb_two;

  // Software clear request: a zero written to a flag position.
  wire [7:0] clr_req = {8{i_sfr_wr & hit_flags}} & ~i_sfr_wdata;

  // Per-bit flag storage; a set in the clearing cycle is kept.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_flag
      always_ff @(posedge i_clk_sys)
      begin
        if (!i_rst_n)
          flags_q[gi] <= FLAGS_RESET[gi];                      // [R19]
        else if (set_req[gi] && LIVE_BITS[gi])
          flags_q[gi] <= 1'b1;                                 // [R19]
        else if (clr_req[gi])
          flags_q[gi] <= 1'b0;                                 // [R19]
      end
    end
  endgenerate

  // Enable register; bits absent on the base variant stay zero.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      enables_q <= ENABLES_RESET;
    else if (i_sfr_wr && hit_enables)
      enables_q <= i_sfr_wdata & LIVE_BITS;           // [R15] [R16] [R17]
  end

  // Period and compare registers, written a byte lane at a time.
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_lane
      always_ff @(posedge i_clk_sys)
      begin
        if (!i_rst_n)
        begin
          period_q[gi*8 +: 8]    <= WRAP_REG_RESET[gi*8 +: 8];
          match_one_q[gi*8 +: 8] <= WRAP_REG_RESET[gi*8 +: 8];
          match_two_q[gi*8 +: 8] <= WRAP_REG_RESET[gi*8 +: 8];
        end
        else
        begin
          if (we_per[gi])
            period_q[gi*8 +: 8] <= i_sfr_wdata;        // [R1] [R4] [R6]
          if (we_m1[gi])
            match_one_q[gi*8 +: 8] <= i_sfr_wdata;
          if (we_m2[gi])
            match_two_q[gi*8 +: 8] <= i_sfr_wdata;
        end
      end
    end
  endgenerate

  // Counter copy, frozen on the chosen latching read.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      latch_q <= WRAP_REG_RESET;
    else if (take_latch)
      latch_q <= i_wrap_counter;                             // [R2] [R3]
  end

  // Read data is registered so the bus sees it one cycle after the
  // strobe; it holds until the next read so slow masters are safe.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      rdata_q <= RDATA_RESET;
    else if (i_sfr_rd)
      rdata_q <= rd_mux;
  end

  // Counter writes travel to the core, which owns the live count.
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
      cwr_q <= '0;
    else
    begin
      cwr_q.lane_we <= we_cnt;                          // [R1] [R4] [R6]
      cwr_q.data    <= i_sfr_wdata;
    end
  end

  // Interrupt: any flag whose enable is set.
  assign o_timer_irq = |(flags_q & enables_q);                // [R20]

  // Output wiring.
  assign o_sfr_rdata      = rdata_q;
  assign o_wrap_period    = period_q;
  assign o_wrap_match_one = match_one_q;
  assign o_wrap_match_two = match_two_q;
  assign o_counter_write  = cwr_q;

  // Checks kept next to the logic they guard.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_low_latch_read;
    i_sfr_rd && hit_low && sel_cnt && !i_latch_mode;
  endsequence

  sequence s_mid_read_counter;
    i_sfr_rd && hit_mid && sel_cnt;
  endsequence

  chk_low_read_latches: assert property ( // [R2]
    s_low_latch_read |=> latch_q == $past(i_wrap_counter))
    else $error("low window read did not freeze the counter");

  chk_timer_read_latches: assert property ( // [R3]
    (i_timer_low_window_rd && sel_cnt && i_latch_mode)
      |=> latch_q == $past(i_wrap_counter))
    else $error("timer low read did not freeze the counter");

  chk_mid_reads_copy: assert property ( // [R5]
    s_mid_read_counter |=> o_sfr_rdata == $past(latch_q[15:8]))
    else $error("middle window did not return the frozen byte");

  chk_high_reads_copy: assert property ( // [R7]
    (i_sfr_rd && hit_high && sel_cnt)
      |=> o_sfr_rdata == $past(latch_q[23:16]))
    else $error("high window did not return the frozen byte");

  chk_period_lane_write: assert property ( // [R4]
    (i_sfr_wr && hit_mid && sel_per)
      |=> o_wrap_period[15:8] == $past(i_sfr_wdata))
    else $error("period middle byte not written");

  chk_flag_set_wins: assert property ( // [R19]
    i_core_events.tick_wrap |=> flags_q[BIT_TICK_WRAP])
    else $error("timer wrap flag not set");

  chk_flag_clear_zero: assert property ( // [R19]
    (i_sfr_wr && hit_flags && !i_sfr_wdata[BIT_WRAP_PERIOD]
     && !i_core_events.wrap_period) |=> !flags_q[BIT_WRAP_PERIOD])
    else $error("write of zero did not clear the flag");

  chk_flag_hold_one: assert property ( // [R19]
    (i_sfr_wr && hit_flags && i_sfr_wdata[BIT_TICK_MATCH_ONE]
     && flags_q[BIT_TICK_MATCH_ONE]) |=> flags_q[BIT_TICK_MATCH_ONE])
    else $error("write of one disturbed a set flag");

  // An enabled hardware set must raise the request on the next cycle,
  // unless software rewrites the enables in that very cycle.
  chk_irq_follows: assert property ( // [R20]
    (|(set_req & LIVE_BITS & enables_q) && !(i_sfr_wr && hit_enables))
      |=> o_timer_irq)
    else $error("enabled event did not raise the interrupt");

  chk_reserved_zero: assert property ( // [R17]
    (!EXTENDED && i_sfr_rd && hit_enables) |=> o_sfr_rdata[7:6] == 2'h0)
    else $error("reserved enable bits read nonzero");

endmodule : timer_wrap_access

// ===== rtl/timer_wrap_pkg.sv
package timer_wrap_pkg;

  // Register addresses on the special-function register bus.
  localparam logic [7:0] ADDR_EVENT_FLAGS    = 8'ha1;
  localparam logic [7:0] ADDR_WRAP_LOW       = 8'ha4;
  localparam logic [7:0] ADDR_WRAP_MID       = 8'ha5;
  localparam logic [7:0] ADDR_WRAP_HIGH      = 8'ha6;
  localparam logic [7:0] ADDR_EVENT_ENABLES  = 8'ha7;

  // Reset values of the directly visible and internal registers.
  localparam logic [7:0]  FLAGS_RESET        = 8'h00;
  localparam logic [7:0]  ENABLES_RESET      = 8'h00;
  localparam logic [23:0] WRAP_REG_RESET     = 24'h000000;
  localparam logic [7:0]  RDATA_RESET        = 8'h00;

  // Codes of the overflow window select field.
  localparam logic [2:0] SEL_COUNTER         = 3'h0;
  localparam logic [2:0] SEL_CAPTURE         = 3'h1;
  localparam logic [2:0] SEL_PERIOD          = 3'h2;
  localparam logic [2:0] SEL_MATCH_ONE       = 3'h3;
  localparam logic [2:0] SEL_MATCH_TWO       = 3'h4;

  // Byte lane indices of a 24-bit internal register.
  localparam logic [1:0] LANE_LOW            = 2'h0;
  localparam logic [1:0] LANE_MID            = 2'h1;
  localparam logic [1:0] LANE_HIGH           = 2'h2;

  // Flag and enable bit positions.
  localparam int BIT_TICK_WRAP        = 0;
  localparam int BIT_TICK_MATCH_ONE   = 1;
  localparam int BIT_TICK_MATCH_TWO   = 2;
  localparam int BIT_WRAP_PERIOD      = 3;
  localparam int BIT_WRAP_MATCH_ONE   = 4;
  localparam int BIT_WRAP_MATCH_TWO   = 5;
  localparam int BIT_COMB_MATCH_ONE   = 6;
  localparam int BIT_COMB_MATCH_TWO   = 7;

  // Base variant implements flag bits 5:0 only.
  localparam logic [7:0] BASE_BITS_MASK  = 8'h3f;
  localparam logic [7:0] FULL_BITS_MASK  = 8'hff;

  // Single-cycle event pulses coming from the counting core.
  typedef struct packed {
    logic wrap_match_two;   // Overflow counter reached match two.
    logic wrap_match_one;   // Overflow counter reached match one.
    logic wrap_period;      // Overflow counter wrapped at its period.
    logic tick_match_two;   // Timer counter reached match two.
    logic tick_match_one;   // Timer counter reached match one.
    logic tick_wrap;        // Timer counter wrapped at its period.
  } core_events_t;

  // Byte write toward the live overflow counter in the core.
  typedef struct packed {
    logic [2:0] lane_we;    // One-hot byte lane strobe.
    logic [7:0] data;       // Byte to store.
  } counter_write_t;

endpackage : timer_wrap_pkg

// ===== testbench/timer_overflow_access_irq_tb.sv
`timescale 1ns/1ps
module timer_overflow_access_irq_tb;
  import timer_wrap_pkg::*;

  // Design inputs; the bus strobes and core events are driven by the bench at rising edges.
  logic           i_clk_sys, i_rst_n, i_sfr_wr, i_sfr_rd;
  logic [7:0]     i_sfr_addr, i_sfr_wdata;
  logic [2:0]     i_overflow_window_select;
  logic           i_latch_mode, i_timer_low_window_rd;
  logic [23:0]    i_wrap_counter, i_wrap_capture;
  core_events_t   i_core_events;
  // Design outputs.
  logic [7:0]     o_sfr_rdata;
  logic [23:0]    o_wrap_period, o_wrap_match_one, o_wrap_match_two;
  counter_write_t o_counter_write;
  logic           o_timer_irq;
  logic [7:0]     rdata_base;
  logic           irq_base;
  // Model state: internal registers by select code, flags and enables.
  int             failures, n_compared, cyc, seed, flg, ena;
  logic [23:0]    wreg [8];
  logic [23:0]    frz;
  logic [7:0]     rv, d;

  timer_wrap_access u_dut (.i_clk_sys, .i_rst_n, .i_sfr_addr, .i_sfr_wr,
    .i_sfr_rd, .i_sfr_wdata, .o_sfr_rdata, .i_overflow_window_select,
    .i_latch_mode, .i_timer_low_window_rd, .i_wrap_counter, .i_wrap_capture,
    .i_core_events, .o_wrap_period, .o_wrap_match_one, .o_wrap_match_two,
    .o_counter_write, .o_timer_irq);

  // Base variant on the same stimulus: bits 7:6 must stay zero.
  timer_wrap_access #(.EXTENDED(1'b0)) u_dut_base (.i_clk_sys, .i_rst_n,
    .i_sfr_addr, .i_sfr_wr, .i_sfr_rd, .i_sfr_wdata,
    .o_sfr_rdata(rdata_base),
    .i_overflow_window_select, .i_latch_mode, .i_timer_low_window_rd,
    .i_wrap_counter, .i_wrap_capture, .i_core_events, .o_wrap_period(),
    .o_wrap_match_one(), .o_wrap_match_two(), .o_counter_write(),
    .o_timer_irq(irq_base));

  // Free-running 125 MHz clock.
  initial
  begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  // Compares one result against the model and counts it.
  task automatic chk(input logic [23:0] seen, exp, input string msg);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops the run.
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  // One write strobe; its effect is visible just after the release edge.
  task automatic wr(input logic [7:0] a, dat);
    @(posedge i_clk_sys);
    i_sfr_addr  <= a;
    i_sfr_wdata <= dat;
    i_sfr_wr    <= 1'b1;
    @(posedge i_clk_sys);
    i_sfr_wr    <= 1'b0;
    #1;
  endtask : wr

  // One read strobe; the data register updates at the sampling edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] dat);
    @(posedge i_clk_sys);
    i_sfr_addr <= a;
    i_sfr_rd   <= 1'b1;
    @(posedge i_clk_sys);
    i_sfr_rd   <= 1'b0;
    #1 dat = o_sfr_rdata;
  endtask : rd

  // One-cycle pulse on one core event line.
  task automatic ev(input int k);
    @(posedge i_clk_sys);
    i_core_events <= core_events_t'(6'(1 << k));
    @(posedge i_clk_sys);
    i_core_events <= '0;
    #1;
  endtask : ev

  // Expected window byte; codes 5 to 7 hold zero in the model.
  function automatic logic [7:0] exp_win(int sel, int ln);
    logic [23:0] r;
    r = (sel == 1) ? i_wrap_capture : wreg[sel];
    return r[8*ln +: 8];
  endfunction : exp_win

  // A hang is cut short here and counted as a mismatch.
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      wrap_up();
    end
  end

  initial
  begin
    {i_rst_n, i_sfr_wr, i_sfr_rd, i_sfr_addr, i_sfr_wdata} = '0;
    {i_overflow_window_select, i_latch_mode, i_timer_low_window_rd} = '0;
    {i_wrap_counter, i_core_events, flg, ena} = '0;
    seed = 86;
    i_wrap_capture = 24'($random(seed));
    foreach (wreg[i]) wreg[i] = '0;
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    // Reset values and the unmapped addresses all read zero.
    foreach (wreg[i])
    begin
      rd(8'ha0 + 8'(i), rv);
      chk(rv, (i == 4) ? i_wrap_counter[7:0] : 8'h00, "reset read");
    end
    chk(o_wrap_period | o_wrap_match_one | o_wrap_match_two, 0, "reset");
    $display("test reset done");
    // Write every lane under every nonzero code; only 2 to 4 store.
    for (int s = 1; s < 8; s++)
      for (int l = 0; l < 3; l++)
      begin
        i_overflow_window_select <= 3'(s);
        d = 8'($random(seed)) | 8'h01;
        wr(8'ha4 + 8'(l), d);
        if (s >= 2 && s <= 4) wreg[s][8*l +: 8] = d;
      end
    chk(o_wrap_period, wreg[2], "period out");
    chk(o_wrap_match_one, wreg[3], "match one out");
    chk(o_wrap_match_two, wreg[4], "match two out");
    for (int s = 1; s < 8; s++)
      for (int l = 0; l < 3; l++)
      begin
        i_overflow_window_select <= 3'(s);
        rd(8'ha4 + 8'(l), rv);
        chk(rv, exp_win(s, l), "window byte");
      end
    $display("test windows done");
    // Mode zero: low read shows live byte and freezes the upper bytes.
    i_overflow_window_select <= 3'h0;
    i_wrap_counter <= 24'($random(seed));
    rd(8'ha4, rv);
    frz = i_wrap_counter;
    chk(rv, frz[7:0], "live low");
    i_wrap_counter <= ~frz;
    rd(8'ha5, rv);
    chk(rv, frz[15:8], "frozen mid");
    rd(8'ha6, rv);
    chk(rv, frz[23:16], "frozen high");
    // Writes with code zero go to the live counter, one lane a pulse.
    for (int l = 0; l < 3; l++)
    begin
      d = 8'($random(seed));
      wr(8'ha4 + 8'(l), d);
      chk(o_counter_write, {3'(1 << l), d}, "counter write");
      @(posedge i_clk_sys);
      #1 chk(o_counter_write.lane_we, 0, "lane pulse");
    end
    $display("test latch mode zero done");
    // Mode one: the timer low read freezes all three bytes.
    i_latch_mode <= 1'b1;
    i_wrap_counter <= 24'($random(seed));
    @(posedge i_clk_sys);
    i_timer_low_window_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_timer_low_window_rd <= 1'b0;
    frz = i_wrap_counter;
    i_wrap_counter <= ~frz;
    for (int l = 0; l < 3; l++)
    begin
      rd(8'ha4 + 8'(l), rv);
      chk(rv, frz[8*l +: 8], "mode one byte");
    end
    i_latch_mode <= 1'b0;
    $display("test latch mode one done");
    // Each event sets its flag; the interrupt follows the enables.
    i_wrap_counter <= '0;
    ena = ($random(seed) & 8'h3f) | 8'h01;
    wr(ADDR_EVENT_ENABLES, 8'(ena));
    for (int k = 0; k < 6; k++)
    begin
      ev(k);
      flg |= 1 << k;
      chk(o_timer_irq, |(flg & ena), "irq");
      rd(ADDR_EVENT_FLAGS, rv);
      chk(rv, 8'(flg), "event flag");
    end
    // Bit 3 is always cleared and bit 1 always kept, so both are seen.
    d = (8'($random(seed)) & 8'hf7) | 8'h02;
    wr(ADDR_EVENT_FLAGS, d);
    flg &= d;
    rd(ADDR_EVENT_FLAGS, rv);
    chk(rv, 8'(flg), "write zero clears");
    // A hardware set beats a software clear in the same cycle.
    @(posedge i_clk_sys);
    i_sfr_addr    <= ADDR_EVENT_FLAGS;
    i_sfr_wdata   <= 8'h00;
    i_sfr_wr      <= 1'b1;
    i_core_events <= core_events_t'(6'h08);
    @(posedge i_clk_sys);
    i_sfr_wr      <= 1'b0;
    i_core_events <= '0;
    rd(ADDR_EVENT_FLAGS, rv);
    chk(rv, 8'h08, "set wins");
    // Combined matches need the counter on the overflow match value.
    i_wrap_counter <= wreg[3];
    ev(1);
    i_wrap_counter <= wreg[4];
    ev(2);
    rd(ADDR_EVENT_FLAGS, rv);
    chk(rv, 8'hce, "combined flags");
    chk(rdata_base, 8'h0e, "base flags");
    wr(ADDR_EVENT_ENABLES, 8'hc0);
    rd(ADDR_EVENT_ENABLES, rv);
    chk(rv, 8'hc0, "enable readback");
    chk(rdata_base, 8'h00, "base enables");
    chk(o_timer_irq, 1'b1, "combined irq");
    chk(irq_base, 1'b0, "base irq");
    wr(ADDR_EVENT_ENABLES, 8'h00);
    chk(o_timer_irq, 1'b0, "masked irq");
    $display("test events done");
    // A reset in mid-run must clear the irq, flags, enables, period, match two, read data and core write.
    wr(ADDR_EVENT_ENABLES, 8'hc0);
    chk(o_timer_irq, 1'b1, "irq before reset");
    @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    #1 chk(o_timer_irq, 1'b0, "irq after reset");
    chk(o_wrap_period | o_wrap_match_two, 0, "regs after reset");
    chk(o_sfr_rdata, 0, "rdata after reset");
    chk(o_counter_write, 0, "core write after reset");
    rd(ADDR_EVENT_FLAGS, rv);
    chk(rv, 8'h00, "flags after reset");
    rd(ADDR_EVENT_ENABLES, rv);
    chk(rv, 8'h00, "enables after reset");
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule : timer_overflow_access_irq_tb
